// ### design/isae_pkg.sv
// Package for the slave-side serial address engine: register map, field
// positions, reset values, bit counts and address class codes.
// Assumes a 32-bit Avalon-MM register bus with byte addressing.
package isae_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [4:0] OFS_SLAVE_ADDRESS = 5'h00;
    localparam logic [4:0] OFS_PORT_CONTROL = 5'h04;
    localparam logic [4:0] OFS_STATUS = 5'h08;
    localparam logic [4:0] OFS_RECEIVE_BUFFER = 5'h0C;
    localparam logic [4:0] OFS_TRANSMIT_REG = 5'h10;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    // port_control
    localparam int CTL_SLAVE_ENABLE = 0;
    localparam int CTL_TEN_BIT_MODE = 1;
    localparam int CTL_SCL_RELEASE = 2;
    // status
    localparam int STS_RX_FULL = 0;
    localparam int STS_RX_OVERFLOW = 1;
    localparam int STS_EVENT = 2;
    localparam int STS_TEN_MATCH = 3;
    localparam int STS_TX_MODE = 4;
    localparam int STS_CLASS_LSB = 5;

    // ----------------------------------------------------------------
    // Widths, reset values and constants
    // ----------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam logic [9:0] SLAVE_ADDRESS_RST = 10'h000;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;

    // Address class of a received 7-bit address
    localparam logic [2:0] CLS_NORMAL = 3'h0;
    localparam logic [2:0] CLS_GENERAL_CALL = 3'h1;
    localparam logic [2:0] CLS_RESERVED_LO = 3'h2;
    localparam logic [2:0] CLS_HS_MASTER = 3'h3;
    localparam logic [2:0] CLS_TEN_BIT_PREFIX = 3'h4;
    localparam logic [2:0] CLS_RESERVED_HI = 3'h5;
    localparam logic [6:0] A7_RSV_LO_MAX = 7'h03;
    localparam logic [6:0] A7_HS_MAX = 7'h07;
    localparam logic [6:0] A7_TEN_MIN = 7'h78;
    localparam logic [6:0] A7_TEN_MAX = 7'h7B;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_ADDR = 4'h1,
        S_ADDR_ACK = 4'h3,
        S_RX = 4'h2,
        S_RX_ACK = 4'h6,
        S_TX_HOLD = 4'h7,
        S_TX = 4'h5,
        S_TX_ACK = 4'h4,
        S_ADDR2 = 4'hB
    } isae_state_e;

endpackage

// ### design/isae_top.sv
// Slave-side serial address engine: address match (7/10 bit), slave
// receive, and slave transmit (7-bit address only) with clock stretching, Avalon-MM registers.
// Assumes open-drain SCL/SDA resolved outside, pins asynchronous to sys_clk.
`timescale 1ns/100ps
module isae_top (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [4:0] avs_address,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n
);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_m_q;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_m_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_n <= rst_m_q;
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers and line events
    // ----------------------------------------------------------------
    logic scl_m_q, scl_s_q, scl_p_q;
    logic sda_m_q, sda_s_q, sda_p_q;
    logic scl_rise, scl_fall, start_det, stop_det;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
        end
    end

    assign scl_rise = scl_s_q & ~scl_p_q;
    assign scl_fall = ~scl_s_q & scl_p_q;
    // SDA moving while SCL stays high marks Start or Stop
    assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [9:0] slave_address_q;
    logic slave_enable_q, ten_bit_address_mode_q, scl_release_q;
    logic receive_buffer_full_q, receive_overflow_q, slave_event_flag_q;
    logic ten_bit_match_flag_q;
    logic [7:0] receive_buffer_q, transmit_register_q;
    logic [2:0] addr_class_q;

    isae_pkg::isae_state_e state_q;
    logic [3:0] cnt_q;
    logic [7:0] receive_shifter_q, tx_shift_q;
    logic rw_q, partial_q, rx_ack_q, master_ack_q;

    // ----------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, then the answer
    // ----------------------------------------------------------------
    logic bus_ack_q, wr_en, rd_en;
    logic [31:0] rdata_d;

    assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack_q;
    assign wr_en = avs_write & bus_ack_q;
    assign rd_en = avs_read & bus_ack_q;

    always_comb begin
        rdata_d = 32'h0000_0000;
        case (avs_address[4:2])
            isae_pkg::OFS_SLAVE_ADDRESS[4:2]: rdata_d[9:0] = slave_address_q;
            isae_pkg::OFS_PORT_CONTROL[4:2]: begin
                rdata_d[isae_pkg::CTL_SLAVE_ENABLE] = slave_enable_q;
                rdata_d[isae_pkg::CTL_TEN_BIT_MODE] = ten_bit_address_mode_q;
                rdata_d[isae_pkg::CTL_SCL_RELEASE] = scl_release_q;
            end
            isae_pkg::OFS_STATUS[4:2]: begin
                rdata_d[isae_pkg::STS_RX_FULL] = receive_buffer_full_q;
                rdata_d[isae_pkg::STS_RX_OVERFLOW] = receive_overflow_q;
                rdata_d[isae_pkg::STS_EVENT] = slave_event_flag_q;
                rdata_d[isae_pkg::STS_TEN_MATCH] = ten_bit_match_flag_q;
                rdata_d[isae_pkg::STS_TX_MODE] = rw_q;
                rdata_d[isae_pkg::STS_CLASS_LSB +: 3] = addr_class_q;
            end
            isae_pkg::OFS_RECEIVE_BUFFER[4:2]: rdata_d[7:0] = receive_buffer_q;
            isae_pkg::OFS_TRANSMIT_REG[4:2]: rdata_d[7:0] = transmit_register_q;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_ack_q <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            bus_ack_q <= (avs_read | avs_write) & ~bus_ack_q;
            if (avs_read & ~bus_ack_q) begin
                avs_readdata <= rdata_d;
            end
        end
    end

    logic wr_addr, wr_ctl, wr_sts, wr_tx, rd_rx;
    assign wr_addr = wr_en && avs_address[4:2] == isae_pkg::OFS_SLAVE_ADDRESS[4:2];
    assign wr_ctl = wr_en && avs_byteenable[0] && avs_address[4:2] == isae_pkg::OFS_PORT_CONTROL[4:2];
    assign wr_sts = wr_en && avs_byteenable[0] && avs_address[4:2] == isae_pkg::OFS_STATUS[4:2];
    assign wr_tx = wr_en && avs_byteenable[0] && avs_address[4:2] == isae_pkg::OFS_TRANSMIT_REG[4:2];
    assign rd_rx = rd_en && avs_address[4:2] == isae_pkg::OFS_RECEIVE_BUFFER[4:2];

    // ----------------------------------------------------------------
    // Address comparison and classification
    // ----------------------------------------------------------------
    logic byte_done, ack_fall, addr7_hit, ten_hi_hit, lo_hit;
    logic [2:0] class_d;
    logic [6:0] a7;

    assign byte_done = scl_fall && cnt_q == isae_pkg::BYTE_BITS;
    assign ack_fall = scl_fall && (state_q == isae_pkg::S_ADDR_ACK || state_q == isae_pkg::S_RX_ACK
                                   || state_q == isae_pkg::S_TX_ACK);
    assign addr7_hit = receive_shifter_q[7:1] == slave_address_q[6:0];
    assign ten_hi_hit = receive_shifter_q[7:3] == isae_pkg::TEN_BIT_PREFIX
                        && receive_shifter_q[2:1] == slave_address_q[9:8];
    assign lo_hit = receive_shifter_q == slave_address_q[7:0];
    assign a7 = receive_shifter_q[7:1];

    always_comb begin
        class_d = isae_pkg::CLS_NORMAL;
        if (a7 == 7'h00) begin
            class_d = isae_pkg::CLS_GENERAL_CALL;
        end else if (a7 <= isae_pkg::A7_RSV_LO_MAX) begin
            class_d = isae_pkg::CLS_RESERVED_LO;
        end else if (a7 <= isae_pkg::A7_HS_MAX) begin
            class_d = isae_pkg::CLS_HS_MASTER;
        end else if (a7 >= isae_pkg::A7_TEN_MIN && a7 <= isae_pkg::A7_TEN_MAX) begin
            class_d = isae_pkg::CLS_TEN_BIT_PREFIX;
        end else if (a7 > isae_pkg::A7_TEN_MAX) begin
            class_d = isae_pkg::CLS_RESERVED_HI;
        end
    end

    // ----------------------------------------------------------------
    // Protocol state machine
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= isae_pkg::S_IDLE;
            cnt_q <= 4'h0;
            receive_shifter_q <= 8'h00;
            tx_shift_q <= 8'hFF;
            rw_q <= 1'b0;
            partial_q <= 1'b0;
            rx_ack_q <= 1'b0;
            master_ack_q <= 1'b0;
            ten_bit_match_flag_q <= 1'b0;
            addr_class_q <= isae_pkg::CLS_NORMAL;
        end else if (!slave_enable_q || stop_det) begin
            state_q <= isae_pkg::S_IDLE;
            cnt_q <= 4'h0;
        end else if (start_det) begin
            state_q <= isae_pkg::S_ADDR;
            cnt_q <= 4'h0;
            rw_q <= 1'b0;
        end else begin
            if (scl_rise && (state_q == isae_pkg::S_ADDR || state_q == isae_pkg::S_ADDR2
                             || state_q == isae_pkg::S_RX)) begin
                receive_shifter_q <= {receive_shifter_q[6:0], sda_s_q};
                cnt_q <= cnt_q + 4'h1;
            end
            case (state_q)
                isae_pkg::S_ADDR: begin
                    if (byte_done) begin
                        cnt_q <= 4'h0;
                        addr_class_q <= class_d;
                        rw_q <= receive_shifter_q[0];
                        if (!ten_bit_address_mode_q) begin
                            partial_q <= 1'b0;
                            state_q <= addr7_hit ? isae_pkg::S_ADDR_ACK : isae_pkg::S_IDLE;
                        end else if (ten_hi_hit && !receive_shifter_q[0]) begin
                            partial_q <= 1'b1;
                            ten_bit_match_flag_q <= 1'b0;
                            state_q <= isae_pkg::S_ADDR_ACK;
                        end else begin
                            ten_bit_match_flag_q <= 1'b0;
                            state_q <= isae_pkg::S_IDLE;
                        end
                    end
                end
                isae_pkg::S_ADDR2: begin
                    if (byte_done) begin
                        cnt_q <= 4'h0;
                        partial_q <= 1'b0;
                        ten_bit_match_flag_q <= lo_hit;
                        state_q <= lo_hit ? isae_pkg::S_ADDR_ACK : isae_pkg::S_IDLE;
                    end
                end
                isae_pkg::S_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (partial_q) begin
                            state_q <= isae_pkg::S_ADDR2;
                        end else if (rw_q) begin
                            state_q <= isae_pkg::S_TX_HOLD;
                        end else begin
                            state_q <= isae_pkg::S_RX;
                        end
                    end
                end
                isae_pkg::S_RX: begin
                    if (byte_done) begin
                        cnt_q <= 4'h0;
                        rx_ack_q <= !receive_buffer_full_q && !receive_overflow_q;
                        state_q <= isae_pkg::S_RX_ACK;
                    end
                end
                isae_pkg::S_RX_ACK: begin
                    if (scl_fall) begin
                        state_q <= isae_pkg::S_RX;
                    end
                end
                isae_pkg::S_TX_HOLD: begin
                    if (scl_release_q) begin
                        tx_shift_q <= transmit_register_q;
                        cnt_q <= 4'h0;
                        state_q <= isae_pkg::S_TX;
                    end
                end
                isae_pkg::S_TX: begin
                    if (scl_fall) begin
                        tx_shift_q <= {tx_shift_q[6:0], 1'b1};
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == isae_pkg::BYTE_BITS - 4'h1) begin
                            state_q <= isae_pkg::S_TX_ACK;
                        end
                    end
                end
                isae_pkg::S_TX_ACK: begin
                    if (scl_rise) begin
                        master_ack_q <= ~sda_s_q;
                    end
                    if (scl_fall) begin
                        // A NACK ends the read; the master follows with Stop
                        state_q <= master_ack_q ? isae_pkg::S_TX_HOLD : isae_pkg::S_IDLE;
                    end
                end
                default: state_q <= isae_pkg::S_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Software-visible control and flags; hardware set wins over clear
    // ----------------------------------------------------------------
    logic rx_load, rx_lost;
    assign rx_load = state_q == isae_pkg::S_RX && byte_done && !receive_buffer_full_q && !start_det;
    assign rx_lost = state_q == isae_pkg::S_RX && byte_done && receive_buffer_full_q && !start_det;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            slave_address_q <= isae_pkg::SLAVE_ADDRESS_RST;
        end else if (wr_addr) begin
            if (avs_byteenable[0]) begin
                slave_address_q[7:0] <= avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
                slave_address_q[9:8] <= avs_writedata[9:8];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            slave_enable_q <= 1'b0;
            ten_bit_address_mode_q <= 1'b0;
            scl_release_q <= 1'b0;
        end else begin
            if (wr_ctl) begin
                slave_enable_q <= avs_writedata[isae_pkg::CTL_SLAVE_ENABLE];
                ten_bit_address_mode_q <= avs_writedata[isae_pkg::CTL_TEN_BIT_MODE];
            end
            // Cleared on entry to the stretch; a write of one in that cycle still wins
            if (wr_ctl && avs_writedata[isae_pkg::CTL_SCL_RELEASE]) begin
                scl_release_q <= 1'b1;
            end else if (ack_fall && ((state_q == isae_pkg::S_ADDR_ACK && rw_q && !partial_q)
                                      || (state_q == isae_pkg::S_TX_ACK && master_ack_q))) begin
                scl_release_q <= 1'b0;
            end else if (state_q == isae_pkg::S_TX) begin
                scl_release_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            receive_buffer_q <= 8'h00;
            receive_buffer_full_q <= 1'b0;
            receive_overflow_q <= 1'b0;
        end else begin
            if (rx_load) begin
                receive_buffer_q <= receive_shifter_q;
                receive_buffer_full_q <= 1'b1;
            end else if (rd_rx) begin
                receive_buffer_full_q <= 1'b0;
            end
            if (rx_lost) begin
                receive_overflow_q <= 1'b1;
            end else if (wr_sts && avs_writedata[isae_pkg::STS_RX_OVERFLOW]) begin
                receive_overflow_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            slave_event_flag_q <= 1'b0;
            transmit_register_q <= 8'h00;
        end else begin
            if (ack_fall && !start_det && !stop_det && slave_enable_q) begin
                slave_event_flag_q <= 1'b1;
            end else if (wr_sts && avs_writedata[isae_pkg::STS_EVENT]) begin
                slave_event_flag_q <= 1'b0;
            end
            if (wr_tx) begin
                transmit_register_q <= avs_writedata[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Open-drain pin drive, registered
    // ----------------------------------------------------------------
    logic sda_drive_d, scl_drive_d;
    assign sda_drive_d = state_q == isae_pkg::S_ADDR_ACK
                         || (state_q == isae_pkg::S_RX_ACK && rx_ack_q)
                         || (state_q == isae_pkg::S_TX && !tx_shift_q[7]);
    assign scl_drive_d = state_q == isae_pkg::S_TX_HOLD && !scl_release_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_oe_n <= 1'b1;
            scl_oe_n <= 1'b1;
        end else begin
            sda_oe_n <= ~sda_drive_d;
            scl_oe_n <= ~scl_drive_d;
        end
    end

    assign sda_o = 1'b0;
    assign scl_o = 1'b0;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence rx_full_done;
        state_q == isae_pkg::S_RX && byte_done && receive_buffer_full_q && !start_det && !stop_det
        && slave_enable_q;
    endsequence
    sequence ovf_empty_done;
        state_q == isae_pkg::S_RX && byte_done && !receive_buffer_full_q && receive_overflow_q
        && !start_det && !stop_det && slave_enable_q;
    endsequence

    chk_bus_answer: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    chk_start_addr: assert property (start_det && slave_enable_q && !stop_det
        |=> state_q == isae_pkg::S_ADDR && cnt_q == 4'h0) else $error("start not taken");
    chk_ack_drive: assert property (state_q == isae_pkg::S_ADDR_ACK |=> !sda_oe_n)
        else $error("address ack not driven");
    chk_event_set: assert property (ack_fall && slave_enable_q && !start_det && !stop_det
        |=> slave_event_flag_q) else $error("event flag not set");
    chk_addr_keeps_buf: assert property (state_q == isae_pkg::S_ADDR |=> $stable(receive_buffer_q))
        else $error("address changed receive buffer");
    chk_full_nack: assert property (rx_full_done |=> !rx_ack_q && $stable(receive_buffer_q) ##1 sda_oe_n)
        else $error("full buffer not refused");
    chk_ovf_load: assert property (ovf_empty_done
        |=> receive_buffer_full_q && !rx_ack_q && receive_buffer_q == $past(receive_shifter_q))
        else $error("overflow load wrong");
    chk_ten_miss: assert property (state_q == isae_pkg::S_ADDR && byte_done && ten_bit_address_mode_q
        && slave_enable_q && !start_det && !stop_det && (!ten_hi_hit || receive_shifter_q[0])
        |=> state_q == isae_pkg::S_IDLE && !ten_bit_match_flag_q) else $error("ten-bit miss not idle");
    chk_scl_stretch: assert property (scl_drive_d |=> !scl_oe_n)
        else $error("clock not stretched");
    chk_tx_sda_stable: assert property (state_q == isae_pkg::S_TX && scl_s_q && scl_p_q
        && $past(state_q) == isae_pkg::S_TX |-> $stable(sda_oe_n)) else $error("data moved while clock high");

endmodule

// ### tb/isae_mst_model.sv
// Bus master model for the slave engine: open-drain SCL and SDA.
// Assumes pull-ups; the bench resolves the wired-AND levels.
`timescale 1ns/100ps
module isae_mst_model (
    output logic scl_m,
    output logic sda_m,
    input wire logic scl_w,
    input wire logic sda_w
);
    initial begin
        scl_m = 1'h1;
        sda_m = 1'h1;
    end
    task automatic start();
        #40 sda_m = 1'h1;
        #40 scl_m = 1'h1;
        #80 sda_m = 1'h0;
        #80 scl_m = 1'h0;
    endtask
    task automatic stop();
        #40 sda_m = 1'h0;
        #40 scl_m = 1'h1;
        #80 sda_m = 1'h1;
        #80;
    endtask
    // SDA moves only while SCL is low; a stretch is waited out, the bench timeout bounds it
    task automatic clk_bit(input logic b, output logic r);
        #40 sda_m = b;
        #40 scl_m = 1'h1;
        wait (scl_w === 1'h1);
        #40 r = sda_w;
        #40 scl_m = 1'h0;
    endtask
    task automatic xfer(input logic [7:0] v, input logic mack, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(v[i], q[i]);
        end
        clk_bit(mack, ack);
        // Low tail so the engine posts its ninth-fall flags before the CPU looks
        #80;
    endtask
endmodule

// ### tb/test_i2c_slave_address_engine.sv
// Bench for the slave engine: CPU over Avalon-MM, master model on the pins.
// Assumes pull-ups on SCL and SDA, resolved here.
`timescale 1ns/100ps
module test_i2c_slave_address_engine;
    logic sys_clk = 1'h0, arst_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
    logic [4:0] avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic avs_waitrequest, scl_oe_n, sda_oe_n, scl_m, sda_m, a;
    logic wait_smp = 1'h1;
    logic [7:0] d;
    int error_cnt = 0, total_checks = 0, cyc = 0;
    wire scl_w = scl_m & scl_oe_n;
    wire sda_w = sda_m & sda_oe_n;
    isae_top dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_byteenable(4'hF),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .scl_i(scl_w), .scl_o(), .scl_oe_n(scl_oe_n), .sda_i(sda_w),
        .sda_o(), .sda_oe_n(sda_oe_n));
    isae_mst_model mst_u (.scl_m(scl_m), .sda_m(sda_m), .scl_w(scl_w), .sda_w(sda_w));
    initial forever #5 sys_clk = ~sys_clk;
    // Waitrequest is combinational; its settled level mid-cycle is the one the next edge sees
    always @(negedge sys_clk) wait_smp = avs_waitrequest;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic bus(input logic wr_n, input logic [4:0] ad, input logic [31:0] wd);
        @(posedge sys_clk);
        avs_address <= ad;
        avs_writedata <= wd;
        avs_write <= !wr_n;
        avs_read <= wr_n;
        do begin
            @(posedge sys_clk);
        end while (wait_smp !== 1'h0);
        q = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
    endtask
    task automatic wr(input logic [4:0] ad, input logic [31:0] wd);
        bus(1'h0, ad, wd);
    endtask
    task automatic rd(input logic [4:0] ad);
        bus(1'h1, ad, 32'h0);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic test_rx();
        wr(isae_pkg::OFS_SLAVE_ADDRESS, 32'h32A);
        wr(isae_pkg::OFS_PORT_CONTROL, 32'h1);
        mst_u.start();
        mst_u.xfer(8'h54, 1'h1, d, a);
        chk(a, 1'h0);
        rd(isae_pkg::OFS_STATUS);
        chk(q[3:0], 4'h4);
        wr(isae_pkg::OFS_STATUS, 32'h4);
        mst_u.xfer(8'h5A, 1'h1, d, a);
        chk(a, 1'h0);
        mst_u.xfer(8'h33, 1'h1, d, a);
        chk(a, 1'h1);
        rd(isae_pkg::OFS_STATUS);
        chk(q[3:0], 4'h7);
        rd(isae_pkg::OFS_RECEIVE_BUFFER);
        chk(q, 32'h5A);
        wr(isae_pkg::OFS_STATUS, 32'h4);
        mst_u.xfer(8'h66, 1'h1, d, a);
        chk(a, 1'h1);
        rd(isae_pkg::OFS_RECEIVE_BUFFER);
        chk(q, 32'h66);
        wr(isae_pkg::OFS_STATUS, 32'h6);
        mst_u.stop();
        $display("test_rx done");
    endtask
    task automatic test_cls();
        logic [6:0] ad [6] = '{7'h00, 7'h02, 7'h05, 7'h79, 7'h7D, 7'h2B};
        for (int i = 0; i < 6; i++) begin
            mst_u.start();
            mst_u.xfer({ad[i], 1'h0}, 1'h1, d, a);
            chk(a, 1'h1);
            rd(isae_pkg::OFS_STATUS);
            chk(q[7:5], (i + 1) % 6);
        end
        mst_u.stop();
        $display("test_cls done");
    endtask
    task automatic test_tx();
        mst_u.start();
        mst_u.xfer(8'h55, 1'h1, d, a);
        chk(a, 1'h0);
        fork
            mst_u.xfer(8'hFF, 1'h1, d, a);
            begin
                repeat (30) @(posedge sys_clk);
                chk(scl_oe_n, 1'h0);
                wr(isae_pkg::OFS_STATUS, 32'h4);
                wr(isae_pkg::OFS_TRANSMIT_REG, 32'hC3);
                wr(isae_pkg::OFS_PORT_CONTROL, 32'h5);
            end
        join
        chk(d, 8'hC3);
        rd(isae_pkg::OFS_STATUS);
        chk(q[4:2], 3'h5);
        mst_u.stop();
        $display("test_tx done");
    endtask
    task automatic test_ten();
        wr(isae_pkg::OFS_PORT_CONTROL, 32'h3);
        for (int i = 0; i < 2; i++) begin
            mst_u.start();
            mst_u.xfer(8'hF6, 1'h1, d, a);
            chk(a, 1'h0);
            rd(isae_pkg::OFS_STATUS);
            chk(q[3:2], 2'h1);
            wr(isae_pkg::OFS_STATUS, 32'h4);
            mst_u.xfer(8'(8'h2A + i), 1'h1, d, a);
            chk(a, i);
            rd(isae_pkg::OFS_STATUS);
            chk(q[3:2], 3 - 3 * i);
        end
        mst_u.start();
        mst_u.xfer(8'hF7, 1'h1, d, a);
        chk(a, 1'h1);
        mst_u.stop();
        $display("test_ten done");
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        arst_n <= 1'h1;
        repeat (3) @(posedge sys_clk);
        test_rx();
        test_cls();
        test_tx();
        test_ten();
        wrap_up();
    end
endmodule
